/* File: design/evtirq_top.sv */
// Event flags, interrupt enables and Avalon-MM register slave
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module evtirq_top
	import evtirq_pkg::*;
(
	// Clock, reset and clock enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Event sources
	input wire evtirq_evt_t evt,
	input wire logic [2:0] fifo_rd_ptr,
	input wire logic [2:0] fifo_wr_ptr,
	// Interrupt request
	output logic irq
);

	evtirq_state_t s;
	evtirq_state_t next_s;

	logic pll_lvl;
	logic sync_lvl;
	logic [7:0] flags_first;
	logic [7:0] flags_second;
	logic [7:0] set_first;
	logic [7:0] set_second;
	logic [7:0] clr_first;
	logic [7:0] clr_second;
	logic [7:0] rd_mux;
	logic [2:0] idx;
	logic [2:0] ptr_diff;
	logic req;
	logic commit;
	logic wr_commit;
	logic pll_lost_evt;
	logic sync_locked_evt;

	// ------------------------------------------------------------------
	// Synchronisers for levels from the analog and sync domains
	// ------------------------------------------------------------------
	evtirq_sync u_sync_pll (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.d(evt.pll_lock),
		.q(pll_lvl)
	);

	evtirq_sync u_sync_lock (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.d(evt.sync_lock),
		.q(sync_lvl)
	);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// One wait state: data are captured first, effects land on release
	assign idx = avs_address[4:2];
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & (~s.ack | ~ce);
	assign commit = ce & req & s.ack;
	assign wr_commit = commit & avs_write & avs_byteenable[0];
	assign avs_readdata = s.rdata;

	// Read mux; reserved and unmapped bits read as zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (idx)
			IDX_EN_FIRST: rd_mux = s.en_first;
			IDX_EN_SECOND: rd_mux = s.en_second;
			IDX_FLAGS_FIRST: rd_mux = flags_first;
			IDX_FLAGS_SECOND: rd_mux = flags_second;
			default: rd_mux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// Event detection
	// ------------------------------------------------------------------
	// Lock lost only counts after lock was seen, so power-up is quiet
	assign pll_lost_evt = s.pll_prev & ~pll_lvl;
	assign sync_locked_evt = ~s.sync_prev & sync_lvl;
	// Pointers wrap, so the difference is taken modulo the depth
	assign ptr_diff = PTR_W'(fifo_wr_ptr - fifo_rd_ptr);

	// Set vectors for both flag registers
	always_comb begin
		set_first = 8'h00;
		set_second = 8'h00;
		set_first[BIT_PLL_LOST] = pll_lost_evt;
		set_first[BIT_SYNC_LOCKED] = sync_locked_evt;
		set_first[BIT_FIFO_WARN1] = (ptr_diff == FIFO_WARN1_DIFF);
		set_first[BIT_FIFO_WARN2] = (ptr_diff == FIFO_WARN2_DIFF);
		set_second[BIT_APC_PASS] = evt.apc_pass;
		set_second[BIT_APC_FAIL] = evt.apc_fail;
		set_second[BIT_SMP_ERR_FAIL] = evt.smp_err_fail;
	end

	// Write of ones clears the matching flags
	always_comb begin
		clr_first = 8'h00;
		clr_second = 8'h00;
		if (wr_commit && idx == IDX_FLAGS_FIRST) begin
			clr_first = avs_writedata[7:0];
		end
		if (wr_commit && idx == IDX_FLAGS_SECOND) begin
			clr_second = avs_writedata[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Flag registers
	// ------------------------------------------------------------------
	evtirq_flagreg #(
		.MASK(FLAGS_FIRST_MASK)
	) u_flags_first (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.set(set_first),
		.clr(clr_first),
		.q(flags_first)
	);

	evtirq_flagreg #(
		.MASK(FLAGS_SECOND_MASK)
	) u_flags_second (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.set(set_second),
		.clr(clr_second),
		.q(flags_second)
	);

	// ------------------------------------------------------------------
	// Next state: bus handshake, enables, edge history
	// ------------------------------------------------------------------
	always_comb begin
		next_s = s;
		if (ce) begin
			next_s.pll_prev = pll_lvl;
			next_s.sync_prev = sync_lvl;
			if (req && !s.ack) begin
				next_s.ack = 1'b1;
				next_s.rdata = {24'h00_0000, rd_mux};
			end else begin
				next_s.ack = 1'b0;
			end
			// Only documented enable bits store; the rest stay zero
			if (wr_commit && idx == IDX_EN_FIRST) begin
				next_s.en_first = avs_writedata[7:0] & EN_FIRST_MASK;
			end
			if (wr_commit && idx == IDX_EN_SECOND) begin
				next_s.en_second = avs_writedata[7:0] & EN_SECOND_MASK;
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s.en_first <= EN_RESET;
			s.en_second <= EN_RESET;
			s.ack <= 1'b0;
			s.rdata <= RDATA_RESET;
			s.pll_prev <= 1'b0;
			s.sync_prev <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------------
	// Level output, follows the flags with no extra latency
	assign irq = (|(flags_first & s.en_first)) |
		(|(flags_second & s.en_second));

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_en_sync;
		@(posedge mclk) disable iff (rst)
		(ce && sync_locked_evt && s.en_first[BIT_SYNC_LOCKED]
			&& !(wr_commit && idx == IDX_EN_FIRST)) |=> irq;
	endproperty
	a_en_sync: assert property (p_en_sync)
		else $error("sync locked did not raise interrupt");

	property p_en_warn1;
		@(posedge mclk) disable iff (rst)
		(flags_first[BIT_FIFO_WARN1] && s.en_first[BIT_FIFO_WARN1]) |-> irq;
	endproperty
	a_en_warn1: assert property (p_en_warn1)
		else $error("enabled warning one without interrupt");

	property p_en_warn2;
		@(posedge mclk) disable iff (rst)
		(ce && wr_commit && idx == IDX_EN_FIRST
			&& avs_writedata[BIT_FIFO_WARN2] && flags_first[BIT_FIFO_WARN2])
			|=> irq;
	endproperty
	a_en_warn2: assert property (p_en_warn2)
		else $error("enabling warning two left interrupt low");

	property p_en_second;
		@(posedge mclk) disable iff (rst)
		((flags_second & s.en_second & EN_SECOND_MASK) != 8'h00) |-> irq;
	endproperty
	a_en_second: assert property (p_en_second)
		else $error("enabled compare flag without interrupt");

	property p_reserved;
		@(posedge mclk) disable iff (rst)
		(ce && wr_commit && idx == IDX_EN_SECOND)
			|=> (s.en_second == ($past(avs_writedata[7:0]) & EN_SECOND_MASK));
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("second enable register stored wrong bits");

	property p_pll_lost;
		@(posedge mclk) disable iff (rst)
		(ce && s.pll_prev && !pll_lvl) |=> flags_first[BIT_PLL_LOST];
	endproperty
	a_pll_lost: assert property (p_pll_lost)
		else $error("lock loss not flagged");

	property p_pll_stays;
		@(posedge mclk) disable iff (rst)
		(flags_first[BIT_PLL_LOST] && !(clr_first[BIT_PLL_LOST] && ce))
			|=> flags_first[BIT_PLL_LOST];
	endproperty
	a_pll_stays: assert property (p_pll_stays)
		else $error("lock lost flag fell without clear");

	property p_fifo_warn;
		@(posedge mclk) disable iff (rst)
		(ce && ptr_diff == FIFO_WARN1_DIFF) |=> flags_first[BIT_FIFO_WARN1];
	endproperty
	a_fifo_warn: assert property (p_fifo_warn)
		else $error("pointer difference one not flagged");

	property p_irq_quiet;
		@(posedge mclk) disable iff (rst)
		(flags_first == 8'h00 && flags_second == 8'h00) |-> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet)
		else $error("interrupt high with no flag set");

	property p_bus_answer;
		@(posedge mclk) disable iff (rst)
		(ce && req && avs_waitrequest) ##1 (ce && $stable(avs_address) && req)
			|-> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer late");

	// ------------------------------------------------------------------
	// Event to flag checks for the other five sources, then mask, clear, freeze and bus checks
	// ------------------------------------------------------------------
	property p_fifo_warn2;
		@(posedge mclk) disable iff (rst)
		(ce && ptr_diff == FIFO_WARN2_DIFF) |=> flags_first[BIT_FIFO_WARN2];
	endproperty
	a_fifo_warn2: assert property (p_fifo_warn2)
		else $error("pointer difference two not flagged");

	property p_sync_flag;
		@(posedge mclk) disable iff (rst)
		(ce && sync_locked_evt) |=> flags_first[BIT_SYNC_LOCKED];
	endproperty
	a_sync_flag: assert property (p_sync_flag)
		else $error("sync locked event not flagged");

	property p_apc_pass_flag;
		@(posedge mclk) disable iff (rst)
		(ce && evt.apc_pass) |=> flags_second[BIT_APC_PASS];
	endproperty
	a_apc_pass_flag: assert property (p_apc_pass_flag)
		else $error("pattern compare pass not flagged");

	property p_apc_fail_flag;
		@(posedge mclk) disable iff (rst)
		(ce && evt.apc_fail) |=> flags_second[BIT_APC_FAIL];
	endproperty
	a_apc_fail_flag: assert property (p_apc_fail_flag)
		else $error("pattern compare fail not flagged");

	property p_smp_err_flag;
		@(posedge mclk) disable iff (rst)
		(ce && evt.smp_err_fail) |=> flags_second[BIT_SMP_ERR_FAIL];
	endproperty
	a_smp_err_flag: assert property (p_smp_err_flag)
		else $error("sample error fail not flagged");

	property p_irq_masked;
		@(posedge mclk) disable iff (rst)
		((flags_first & s.en_first) == 8'h00
			&& (flags_second & s.en_second) == 8'h00) |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt high with every flag masked");

	// Write-one clear seen from the top, a bit set by a same-cycle event is left out of the check
	property p_clr_first;
		@(posedge mclk) disable iff (rst)
		(clr_first != 8'h00) |=> ((flags_first & $past(clr_first)
			& ~$past(set_first)) == 8'h00);
	endproperty
	a_clr_first: assert property (p_clr_first)
		else $error("write of one left a first flag set");

	// Clock enable low must freeze both flag registers and both enable registers
	property p_freeze;
		@(posedge mclk) disable iff (rst)
		!ce |=> ($stable(flags_first) && $stable(flags_second)
			&& $stable(s.en_first) && $stable(s.en_second));
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

	property p_wait_idle;
		@(posedge mclk) disable iff (rst)
		!req |-> !avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle)
		else $error("waitrequest high with no request");

	property p_rdata_high;
		@(posedge mclk) disable iff (rst)
		(avs_read && !avs_waitrequest) |-> (avs_readdata[31:8] == 24'h00_0000);
	endproperty
	a_rdata_high: assert property (p_rdata_high)
		else $error("read data upper bytes not zero");

endmodule : evtirq_top
`default_nettype wire

/* File: design/evtirq_pkg.sv */
// Package for the event flag and interrupt enable block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package evtirq_pkg;

	// ------------------------------------------------------------------
	// Bus geometry and register indices (byte address = index * 4)
	// ------------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam logic [2:0] IDX_EN_FIRST = 3'h4;
	localparam logic [2:0] IDX_EN_SECOND = 3'h5;
	localparam logic [2:0] IDX_FLAGS_FIRST = 3'h6;
	localparam logic [2:0] IDX_FLAGS_SECOND = 3'h7;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int BIT_PLL_LOST = 7;
	localparam int BIT_SYNC_LOCKED = 4;
	localparam int BIT_FIFO_WARN1 = 1;
	localparam int BIT_FIFO_WARN2 = 0;
	localparam int BIT_APC_PASS = 4;
	localparam int BIT_APC_FAIL = 3;
	localparam int BIT_SMP_ERR_FAIL = 2;

	// ------------------------------------------------------------------
	// Implemented bits and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] EN_FIRST_MASK = 8'h13;
	localparam logic [7:0] EN_SECOND_MASK = 8'h1C;
	localparam logic [7:0] FLAGS_FIRST_MASK = 8'h93;
	localparam logic [7:0] FLAGS_SECOND_MASK = 8'h1C;
	localparam logic [7:0] EN_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// ------------------------------------------------------------------
	// FIFO pointer proximity
	// ------------------------------------------------------------------
	localparam int PTR_W = 3;
	localparam logic [2:0] FIFO_WARN1_DIFF = 3'h1;
	localparam logic [2:0] FIFO_WARN2_DIFF = 3'h2;

	// ------------------------------------------------------------------
	// Carriers and state types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic pll_lock;
		logic sync_lock;
		logic apc_pass;
		logic apc_fail;
		logic smp_err_fail;
	} evtirq_evt_t;

	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} evtirq_sync_t;

	typedef struct packed {
		logic [7:0] q;
	} evtirq_flag_t;

	typedef struct packed {
		logic [7:0] en_first;
		logic [7:0] en_second;
		logic ack;
		logic [31:0] rdata;
		logic pll_prev;
		logic sync_prev;
	} evtirq_state_t;

endpackage : evtirq_pkg

/* File: design/evtirq_sync.sv */
// Three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module evtirq_sync
	import evtirq_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Level from another domain and its clean copy
	input wire logic d,
	output logic q
);

	evtirq_sync_t s;
	evtirq_sync_t next_s;

	// ------------------------------------------------------------------
	// Next state: first stage feeds only the second
	// ------------------------------------------------------------------
	always_comb begin
		next_s = s;
		if (ce) begin
			next_s.ff1 = d;
			next_s.ff2 = s.ff1;
			next_s.ff3 = s.ff2;
			// Accept a change only once two late stages agree
			if (s.ff2 == s.ff3) begin
				next_s.level = s.ff3;
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.level;

endmodule : evtirq_sync
`default_nettype wire

/* File: design/evtirq_flagreg.sv */
// Sticky event flag register, write one to clear, set wins
`timescale 1ns/1ps
`default_nettype none
module evtirq_flagreg
	import evtirq_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hFF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Event sets and software clears
	input wire logic [7:0] set,
	input wire logic [7:0] clr,
	// Flag contents
	output logic [7:0] q
);

	evtirq_flag_t s;
	evtirq_flag_t next_s;

	// Set over clear so an event in the clearing cycle is kept
	always_comb begin
		next_s = s;
		if (ce) begin
			next_s.q = ((s.q & ~clr) | set) & MASK;
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s.q <= FLAGS_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_flag_hold;
		@(posedge mclk) disable iff (rst)
		(ce && (clr & s.q) == 8'h00) |=> ((s.q & $past(s.q)) == $past(s.q));
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag dropped without a clearing write");

	property p_flag_clear;
		@(posedge mclk) disable iff (rst)
		(ce && (clr & ~set & MASK) != 8'h00)
			|=> ((s.q & $past(clr) & ~$past(set) & MASK) == 8'h00);
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("write of one did not clear flag");

	property p_set_wins;
		@(posedge mclk) disable iff (rst)
		(ce && (set & clr & MASK) != 8'h00)
			|=> ((s.q & $past(set) & $past(clr) & MASK)
				== ($past(set) & $past(clr) & MASK));
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost during clear");

endmodule : evtirq_flagreg
`default_nettype wire

/* File: test/test_evtirq_top.sv */
// Self-checking bench for the event flag and interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module test_evtirq_top;
	import evtirq_pkg::*;

	// ------------------------------------------------------------------
	// Signals and design instance
	// ------------------------------------------------------------------
	logic mclk;
	logic rst;
	logic ce;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	evtirq_evt_t evt;
	logic [2:0] fifo_rd_ptr;
	logic [2:0] fifo_wr_ptr;
	logic irq;
	int n_mismatch;
	int check_count;
	logic [7:0] rd;
	// Byte addresses of the four registers
	localparam logic [4:0] A_EN1 = 5'h10;
	localparam logic [4:0] A_EN2 = 5'h14;
	localparam logic [4:0] A_FL1 = 5'h18;
	localparam logic [4:0] A_FL2 = 5'h1C;

	evtirq_top u_evtirq_top (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.evt(evt),
		.fifo_rd_ptr(fifo_rd_ptr),
		.fifo_wr_ptr(fifo_wr_ptr),
		.irq(irq)
	);

	// ------------------------------------------------------------------
	// Clock, 5 ns period
	// ------------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ------------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------------
	task finish_test;
		$display("Mismatches %0d of %0d checks", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	task check_reg(input string what, input logic [7:0] exp);
		check_count++;
		if (rd !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, rd);
		end
	endtask : check_reg

	task check_irq(input string what, input logic exp);
		check_count++;
		if (irq !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", what, exp, irq);
		end
	endtask : check_irq

	// ------------------------------------------------------------------
	// Avalon-MM master; each wait bounded so a stuck slave ends the run
	// ------------------------------------------------------------------
	task bus_wait;
		int n;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0) begin
				return;
			end
		end
		n_mismatch++;
		$display("[ERR] waitrequest expected 0 seen stuck");
		finish_test();
	endtask : bus_wait

	task bus_write(input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] be);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= be;
		avs_write <= 1'b1;
		bus_wait();
		avs_write <= 1'b0;
	endtask : bus_write

	task bus_read(input logic [4:0] a);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= 1'b1;
		bus_wait();
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
	endtask : bus_read

	task rd_chk(input logic [4:0] a, input logic [7:0] exp, input string w);
		bus_read(a);
		check_reg(w, exp);
	endtask : rd_chk

	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick

	// One-cycle pulse on an event input, then let the flag land
	task pulse_evt(input int i);
		@(posedge mclk);
		evt[i] <= 1'b1;
		@(posedge mclk);
		evt[i] <= 1'b0;
		tick(3);
	endtask : pulse_evt

	// One cycle of a given pointer pair, then pointers equal again
	task ptr_step(input logic [2:0] wr, input logic [2:0] rp);
		@(posedge mclk);
		fifo_wr_ptr <= wr;
		fifo_rd_ptr <= rp;
		@(posedge mclk);
		fifo_wr_ptr <= rp;
		tick(3);
	endtask : ptr_step

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int b;
		n_mismatch = 0;
		check_count = 0;
		rst = 1'b1;
		ce = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		evt = '0;
		evt.pll_lock = 1'b1;
		fifo_rd_ptr = 3'h0;
		fifo_wr_ptr = 3'h0;
		tick(6);
		rst <= 1'b0;
		// Reset values, and a lock held through reset is no loss
		tick(8);
		rd_chk(A_EN1, 8'h00, "en_first reset");
		rd_chk(A_EN2, 8'h00, "en_second reset");
		rd_chk(A_FL1, 8'h00, "flags_first reset");
		rd_chk(A_FL2, 8'h00, "flags_second reset");
		check_irq("irq reset", 1'b0);
		// Byte enable low and unmapped writes leave nothing behind
		bus_write(A_EN2, 8'h1C, 4'h0);
		rd_chk(A_EN2, 8'h00, "en_second no byteenable");
		bus_write(5'h00, 8'hFF, 4'hF);
		rd_chk(5'h00, 8'h00, "unmapped read");
		// Only the documented enable bits are stored
		bus_write(A_EN1, 8'hFF, 4'hF);
		rd_chk(A_EN1, 8'h13, "en_first all ones");
		bus_write(A_EN2, 8'hFF, 4'hF);
		rd_chk(A_EN2, 8'h1C, "en_second all ones");
		bus_write(A_EN1, 8'h00, 4'hF);
		bus_write(A_EN2, 8'h00, 4'hF);
		// Compare events: masked first, then enabled, then cleared
		for (b = 2; b <= 4; b++) begin
			pulse_evt(b - 2);
			rd_chk(A_FL2, 8'h01 << b, "flags_second set");
			check_irq("irq masked", 1'b0);
			bus_write(A_EN2, 8'h01 << b, 4'hF);
			tick(1);
			check_irq("irq enabled", 1'b1);
			bus_write(A_FL2, 8'h01 << b, 4'hF);
			rd_chk(A_FL2, 8'h00, "flags_second cleared");
			check_irq("irq after clear", 1'b0);
			bus_write(A_EN2, 8'h00, 4'hF);
		end
		// Clock enable low freezes the flags against an event
		@(posedge mclk);
		ce <= 1'b0;
		pulse_evt(2);
		ce <= 1'b1;
		rd_chk(A_FL2, 8'h00, "frozen while ce low");
		// PLL loss latches and survives relock
		@(posedge mclk);
		evt.pll_lock <= 1'b0;
		tick(10);
		rd_chk(A_FL1, 8'h80, "pll lost set");
		@(posedge mclk);
		evt.pll_lock <= 1'b1;
		tick(10);
		rd_chk(A_FL1, 8'h80, "pll lost after relock");
		bus_write(A_FL1, 8'h00, 4'hF);
		rd_chk(A_FL1, 8'h80, "write zero keeps flag");
		bus_write(A_FL1, 8'h80, 4'hF);
		rd_chk(A_FL1, 8'h00, "pll lost cleared");
		// Sync locked: rising level sets the flag once
		bus_write(A_EN1, 8'h10, 4'hF);
		@(posedge mclk);
		evt.sync_lock <= 1'b1;
		tick(10);
		rd_chk(A_FL1, 8'h10, "sync locked set");
		check_irq("irq sync locked", 1'b1);
		bus_write(A_FL1, 8'h10, 4'hF);
		rd_chk(A_FL1, 8'h00, "sync locked cleared");
		check_irq("irq sync cleared", 1'b0);
		// FIFO proximity, including pointer wrap
		bus_write(A_EN1, 8'h02, 4'hF);
		ptr_step(3'h3, 3'h2);
		rd_chk(A_FL1, 8'h02, "warn1 diff one");
		check_irq("irq warn1", 1'b1);
		ptr_step(3'h1, 3'h7);
		rd_chk(A_FL1, 8'h03, "warn2 diff two wrap");
		bus_write(A_FL1, 8'h02, 4'hF);
		rd_chk(A_FL1, 8'h01, "warn1 cleared");
		check_irq("irq warn2 masked", 1'b0);
		bus_write(A_EN1, 8'h01, 4'hF);
		tick(1);
		check_irq("irq warn2 enabled", 1'b1);
		bus_write(A_FL1, 8'h01, 4'hF);
		tick(1);
		check_irq("irq warn2 cleared", 1'b0);
		ptr_step(3'h5, 3'h2);
		rd_chk(A_FL1, 8'h00, "diff three no warn");
		finish_test();
	end

endmodule : test_evtirq_top
`default_nettype wire
